// ---- shared/hsr_pkg.sv ----
// Shared constants and types for the hardware status register groups
package hsr_pkg;
	// Register width
	localparam int unsigned HSR_W = 16;

	// Group selectors on the command port
	typedef enum logic {
		HSR_GRP_CAL,
		HSR_GRP_HW2
	} hsr_grp_t;

	// Status commands, one per register access
	typedef enum logic [2:0] {
		HSR_CMD_RD_COND,
		HSR_CMD_RD_RISE,
		HSR_CMD_RD_FALL,
		HSR_CMD_RD_EVENT,
		HSR_CMD_RD_ENABLE,
		HSR_CMD_WR_RISE,
		HSR_CMD_WR_FALL,
		HSR_CMD_WR_ENABLE
	} hsr_cmd_t;

	// Reset values of the filter, enable and event registers
	localparam logic [15:0] HSR_RISE_RST   = 16'h7fff;
	localparam logic [15:0] HSR_FALL_RST   = 16'h0000;
	localparam logic [15:0] HSR_ENABLE_RST = 16'h0000;
	localparam logic [15:0] HSR_EVENT_RST  = 16'h0000;

	// Bit always reading zero in every condition register
	localparam int unsigned HSR_BIT_NOT_USED = 15;

	// Valid condition bits, second hardware group (bits 11..5, 2..0)
	localparam logic [15:0] HSR_HW2_COND_MASK = 16'h0fe7;
	// Valid condition bits, calibration group (bits 4..0)
	localparam logic [15:0] HSR_CAL_COND_MASK = 16'h001f;

	// Second hardware group bit positions
	localparam int unsigned HW2_BIT_ACP_INCONSIST = 11;
	localparam int unsigned HW2_BIT_ACP_TOO_WIDE  = 10;
	localparam int unsigned HW2_BIT_AF1_NOTCH     = 9;
	localparam int unsigned HW2_BIT_AF2_VOLTAGE   = 8;
	localparam int unsigned HW2_BIT_FM_DEV        = 7;
	localparam int unsigned HW2_BIT_AM_FM         = 6;
	localparam int unsigned HW2_BIT_AUDIO_RANGE   = 5;
	localparam int unsigned HW2_BIT_OFFSET_FREQ   = 2;
	localparam int unsigned HW2_BIT_GEN_AMPL      = 1;
	localparam int unsigned HW2_BIT_REF_LEVEL     = 0;

	// Calibration group bit positions
	localparam int unsigned CAL_BIT_TX_AUTOZERO = 4;
	localparam int unsigned CAL_BIT_VOLTMETER   = 3;
	localparam int unsigned CAL_BIT_COUNTER     = 2;
	localparam int unsigned CAL_BIT_SAMPLER     = 1;
	localparam int unsigned CAL_BIT_SPECTRUM    = 0;
endpackage

// ---- rtl/hsr_group.sv ----
// One status register group: condition, filters, event, enable, summary
module hsr_group
	import hsr_pkg::*;
#(
	parameter int unsigned W = hsr_pkg::HSR_W,
	parameter logic [15:0] COND_MASK = hsr_pkg::HSR_HW2_COND_MASK
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Raw condition inputs
	input  wire logic [W-1:0] cond_in,
	// Register access strobes
	input  wire logic         wr_rise,
	input  wire logic         wr_fall,
	input  wire logic         wr_enable,
	input  wire logic         rd_event,
	input  wire logic         clear_status,
	input  wire logic [W-1:0] wr_data,
	// Register contents
	output logic      [W-1:0] cond_q,
	output logic      [W-1:0] rise_q,
	output logic      [W-1:0] fall_q,
	output logic      [W-1:0] event_q,
	output logic      [W-1:0] enable_q,
	output logic              summary
);
	logic [W-1:0] cond_ff, rise_ff, fall_ff, event_ff, enable_ff;
	logic [W-1:0] nxt_cond, nxt_rise, nxt_fall, nxt_event, nxt_enable;
	logic [W-1:0] latched;

	// Next-state for all group registers
	always_comb begin
		nxt_cond   = cond_in & W'(COND_MASK);                        // RULE6 RULE18
		nxt_cond[HSR_BIT_NOT_USED] = 1'b0;                           // RULE6
		nxt_rise   = wr_rise   ? wr_data : rise_ff;                  // RULE5 RULE19
		nxt_fall   = wr_fall   ? wr_data : fall_ff;                  // RULE5 RULE19
		nxt_enable = wr_enable ? wr_data : enable_ff;                // RULE3
		// Edges seen through the filters
		latched    = (nxt_cond & ~cond_ff & rise_ff)
		           | (~nxt_cond & cond_ff & fall_ff);                // RULE17
		// New events win over a clear in the same cycle
		nxt_event  = ((rd_event || clear_status) ? '0 : event_ff)
		           | latched;                                         // RULE2 RULE17
	end

	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cond_ff   <= '0;
			rise_ff   <= W'(HSR_RISE_RST);
			fall_ff   <= W'(HSR_FALL_RST);
			event_ff  <= W'(HSR_EVENT_RST);
			enable_ff <= W'(HSR_ENABLE_RST);
		end else begin
			cond_ff   <= nxt_cond;
			rise_ff   <= nxt_rise;
			fall_ff   <= nxt_fall;
			event_ff  <= nxt_event;
			enable_ff <= nxt_enable;
		end
	end

	assign cond_q   = cond_ff;
	assign rise_q   = rise_ff;
	assign fall_q   = fall_ff;
	assign event_q  = event_ff;
	assign enable_q = enable_ff;
	assign summary  = |(event_ff & enable_ff);                       // RULE16 RULE18

	// Checks local to one group
	bit_fifteen_zero_a: assert property (@(posedge clk) disable iff (rst)
		!cond_ff[HSR_BIT_NOT_USED])                                  // RULE6
		else $error("condition bit 15 set");
	enable_write_a: assert property (@(posedge clk) disable iff (rst)
		wr_enable |=> enable_ff == $past(wr_data))                   // RULE3
		else $error("enable write not stored");
	filter_write_a: assert property (@(posedge clk) disable iff (rst)
		wr_rise && !wr_fall |=> rise_ff == $past(wr_data) && $stable(fall_ff)) // RULE19
		else $error("rise filter write wrong");
	rise_latch_a: assert property (@(posedge clk) disable iff (rst)
		(|(~cond_ff & nxt_cond & rise_ff)) |=> |event_ff)             // RULE17
		else $error("rising edge not latched");
	summary_or_a: assert property (@(posedge clk) disable iff (rst)
		summary == |(event_ff & enable_ff))                          // RULE16
		else $error("summary mismatch");
endmodule

// ---- rtl/hsr_status_regs.sv ----
// Top of the calibration and second hardware status register groups
//
// Functional notes
// RULE1: Groups hold condition, filters, event, enable, summary
// RULE2: Event clears on query or clear-status
// RULE3: Enable stores written value; zero clears it
// RULE4: Enable may be written and read back
// RULE5: Both filters readable and writable
// RULE6: Condition bit 15 always reads zero
// RULE7: Bits 11,10 flag channel bandwidth problems
// RULE8: Bits 9,8 flag audio generator limits
// RULE9: Bit 7 flags FM deviation too large
// RULE10: Bit 6 flags simultaneous AM and FM
// RULE11: Bit 5 audio autorange error; 4,3 unassigned
// RULE12: Bit 2 flags offset frequency mismatch
// RULE13: Bit 1 flags generator amplitude too high
// RULE14: Bit 0 flags analyzer reference level wrong
// RULE15: Calibration bits 4..0 flag calibration failures
// RULE16: Summary set while enabled events pending
// RULE17: Events latch on filtered condition edges
// RULE18: Summary is OR of event AND enable
// RULE19: Filter writes store full value, reads harmless
module hsr_status_regs
	import hsr_pkg::*;
#(
	parameter int unsigned W = hsr_pkg::HSR_W
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Status command port from the remote controller
	input  wire logic              cmd_valid,
	input  wire hsr_pkg::hsr_grp_t cmd_group,
	input  wire hsr_pkg::hsr_cmd_t cmd_op,
	input  wire logic [W-1:0]      cmd_data,
	input  wire logic              clear_status,
	output logic                   rsp_valid,
	output logic      [W-1:0]      rsp_data,
	// Second hardware group conditions
	input  wire logic              acp_bw_inconsistent,
	input  wire logic              acp_bw_too_wide,
	input  wire logic              first_audio_generator_notch_range,
	input  wire logic              second_audio_generator_voltage_high,
	input  wire logic              fm_deviation_too_large,
	input  wire logic              am_fm_requested,
	input  wire logic              audio_autorange_error,
	input  wire logic              offset_freq_mismatch,
	input  wire logic              gen_amplitude_too_high,
	input  wire logic              ref_level_out_of_range,
	// Calibration group conditions
	input  wire logic              tx_autozero_failed,
	input  wire logic              voltmeter_cal_failed,
	input  wire logic              counter_cal_failed,
	input  wire logic              sampler_cal_failed,
	input  wire logic              spectrum_cal_failed,
	// Summary messages
	output logic                   cal_summary,
	output logic                   second_hardware_group_summary,
	// Combination refused by the device
	output logic                   am_fm_not_permitted
);
	import hsr_pkg::*;

	localparam int unsigned NGRP = 2;

	logic [W-1:0] raw_cond [NGRP];
	logic [W-1:0] cond_q   [NGRP];
	logic [W-1:0] rise_q   [NGRP];
	logic [W-1:0] fall_q   [NGRP];
	logic [W-1:0] event_q  [NGRP];
	logic [W-1:0] enable_q [NGRP];
	logic         summ     [NGRP];
	logic [NGRP-1:0] sel;
	logic         rsp_valid_ff, nxt_rsp_valid;
	logic [W-1:0] rsp_data_ff, nxt_rsp_data;
	logic         amfm_ff, nxt_amfm;

	// Group decode used by the group strobes; the read mux decodes cmd_group itself
	function automatic logic [NGRP-1:0] grp_dec(input hsr_grp_t g);
		grp_dec = (g == HSR_GRP_CAL) ? 2'b01 : 2'b10;
	endfunction

	assign sel = cmd_valid ? grp_dec(cmd_group) : '0;

	// Condition bit mapping; unassigned bits stay zero
	always_comb begin
		raw_cond[0] = '0;
		raw_cond[0][CAL_BIT_TX_AUTOZERO] = tx_autozero_failed;        // RULE15
		raw_cond[0][CAL_BIT_VOLTMETER]   = voltmeter_cal_failed;      // RULE15
		raw_cond[0][CAL_BIT_COUNTER]     = counter_cal_failed;        // RULE15
		raw_cond[0][CAL_BIT_SAMPLER]     = sampler_cal_failed;        // RULE15
		raw_cond[0][CAL_BIT_SPECTRUM]    = spectrum_cal_failed;       // RULE15
		raw_cond[1] = '0;
		raw_cond[1][HW2_BIT_ACP_INCONSIST] = acp_bw_inconsistent;     // RULE7
		raw_cond[1][HW2_BIT_ACP_TOO_WIDE]  = acp_bw_too_wide;         // RULE7
		raw_cond[1][HW2_BIT_AF1_NOTCH]     = first_audio_generator_notch_range;  // RULE8
		raw_cond[1][HW2_BIT_AF2_VOLTAGE]   = second_audio_generator_voltage_high; // RULE8
		raw_cond[1][HW2_BIT_FM_DEV]        = fm_deviation_too_large;  // RULE9
		raw_cond[1][HW2_BIT_AM_FM]         = am_fm_requested;         // RULE10
		raw_cond[1][HW2_BIT_AUDIO_RANGE]   = audio_autorange_error;   // RULE11
		raw_cond[1][HW2_BIT_OFFSET_FREQ]   = offset_freq_mismatch;    // RULE12
		raw_cond[1][HW2_BIT_GEN_AMPL]      = gen_amplitude_too_high;  // RULE13
		raw_cond[1][HW2_BIT_REF_LEVEL]     = ref_level_out_of_range;  // RULE14
	end

	// One group per status register set, each with its own condition mask
	for (genvar g = 0; g < NGRP; g++) begin : g_grp
		hsr_group #(
			.W         (W),
			.COND_MASK (g == 0 ? HSR_CAL_COND_MASK : HSR_HW2_COND_MASK)
		) u_grp (
			.clk          (clk),
			.rst          (rst),
			.cond_in      (raw_cond[g]),
			.wr_rise      (sel[g] && cmd_op == HSR_CMD_WR_RISE),     // RULE5
			.wr_fall      (sel[g] && cmd_op == HSR_CMD_WR_FALL),     // RULE5
			.wr_enable    (sel[g] && cmd_op == HSR_CMD_WR_ENABLE),   // RULE4
			.rd_event     (sel[g] && cmd_op == HSR_CMD_RD_EVENT),    // RULE2
			.clear_status (clear_status),                             // RULE2
			.wr_data      (cmd_data),
			.cond_q       (cond_q[g]),
			.rise_q       (rise_q[g]),
			.fall_q       (fall_q[g]),
			.event_q      (event_q[g]),
			.enable_q     (enable_q[g]),
			.summary      (summ[g])                                   // RULE1
		);
	end

	// Query answer; event read returns value before it clears
	always_comb begin
		int unsigned gi;
		gi            = (cmd_group == HSR_GRP_CAL) ? 0 : 1;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data  = rsp_data_ff;
		if (cmd_valid) begin
			case (cmd_op)
				HSR_CMD_RD_COND: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = cond_q[gi];
				end
				HSR_CMD_RD_RISE: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = rise_q[gi];                      // RULE5
				end
				HSR_CMD_RD_FALL: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = fall_q[gi];                      // RULE5
				end
				HSR_CMD_RD_EVENT: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = event_q[gi];                     // RULE2
				end
				HSR_CMD_RD_ENABLE: begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = enable_q[gi];                    // RULE4
				end
				default: begin
					nxt_rsp_valid = 1'b0;
				end
			endcase
		end
	end

	// AM plus FM is refused while both are asked for
	always_comb begin
		nxt_amfm = am_fm_requested;                                  // RULE10
	end

	// Response and refusal registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= '0;
			amfm_ff      <= 1'b0;
		end else begin
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff  <= nxt_rsp_data;
			amfm_ff      <= nxt_amfm;
		end
	end

	assign rsp_valid                     = rsp_valid_ff;
	assign rsp_data                      = rsp_data_ff;
	assign cal_summary                   = summ[0];                  // RULE16
	assign second_hardware_group_summary = summ[1];                  // RULE16
	assign am_fm_not_permitted           = amfm_ff;                  // RULE10

	// Event query sequence: answer next cycle, AM/FM event bit then zero
	sequence ev_query_s;
		cmd_valid && cmd_op == HSR_CMD_RD_EVENT && cmd_group == HSR_GRP_HW2
			&& !am_fm_requested && !acp_bw_inconsistent
			&& !cond_q[1][HW2_BIT_AM_FM];
	endsequence
	sequence ev_answer_s;
		##1 rsp_valid;
	endsequence
	event_query_clear_a: assert property (@(posedge clk) disable iff (rst)
		ev_query_s |-> ev_answer_s ##0 (event_q[1][HW2_BIT_AM_FM] == 1'b0)) // RULE2
		else $error("event bit not cleared after query");
	enable_readback_a: assert property (@(posedge clk) disable iff (rst)
		cmd_valid && cmd_op == HSR_CMD_WR_ENABLE && cmd_group == HSR_GRP_CAL
		##1 cmd_valid && cmd_op == HSR_CMD_RD_ENABLE && cmd_group == HSR_GRP_CAL
		|=> rsp_data == $past(cmd_data, 2))                          // RULE4
		else $error("enable readback mismatch");
	amfm_cond_a: assert property (@(posedge clk) disable iff (rst)
		am_fm_requested |=> cond_q[1][HW2_BIT_AM_FM] && am_fm_not_permitted) // RULE10
		else $error("am fm condition not flagged");
	clear_status_a: assert property (@(posedge clk) disable iff (rst)
		clear_status && !am_fm_requested && !$past(am_fm_requested) && !(|raw_cond[0])
		&& cond_q[0] == '0 |=> event_q[0] == '0)                    // RULE2
		else $error("clear status left calibration events");
	cal_bit_map_a: assert property (@(posedge clk) disable iff (rst)
		tx_autozero_failed |=> cond_q[0][CAL_BIT_TX_AUTOZERO])        // RULE15
		else $error("calibration bit 4 not reported");
	unassigned_zero_a: assert property (@(posedge clk) disable iff (rst)
		cond_q[1][4:3] == 2'b00 && cond_q[1][15:12] == 4'h0)         // RULE11
		else $error("unassigned condition bit set");
endmodule

// ---- test/hsr_ctrl_model.sv ----
// Remote controller model issuing status commands to the register groups
module hsr_ctrl_model
	import hsr_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// Command port toward the device
	output logic             cmd_valid,
	output hsr_grp_t         cmd_group,
	output hsr_cmd_t         cmd_op,
	output logic      [15:0] cmd_data,
	// Answers from the device
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle port at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_group = HSR_GRP_CAL;
		cmd_op    = HSR_CMD_RD_COND;
		cmd_data  = 16'h0000;
	end

	// One command; reads wait for the answer one edge after taking
	task automatic xfer(input hsr_grp_t g, input hsr_cmd_t op, input logic [15:0] d,
			output logic [15:0] q, output logic got);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_group <= g;
		cmd_op    <= op;
		cmd_data  <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		// Released data inverted, so a stale value cannot pass for a good one
		cmd_data  <= ~d;
		got = 1'b0;
		q   = 16'h0000;
		if (op <= HSR_CMD_RD_ENABLE) begin
			// Answer stands for the cycle after the taking edge; look mid-cycle
			@(negedge clk);
			got = rsp_valid;
			q   = rsp_data;
		end
	endtask
endmodule

// ---- test/hsr_status_regs_bench.sv ----
// Self-checking bench for the two status register groups
module hsr_status_regs_bench;
	import hsr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// Row: group, raw input, rise filter, enable, expected cond, event, summary
	typedef struct {
		hsr_grp_t    g;
		logic [15:0] cin;
		logic [15:0] rise;
		logic [15:0] en;
		logic [15:0] x_cond;
		logic [15:0] x_ev;
		logic        x_sum;
	} hsr_row_t;

	logic        clk;
	logic        rst;
	logic        clear_status;
	logic [15:0] cond_hw;
	logic [15:0] cond_cal;
	logic        cmd_valid;
	hsr_grp_t    cmd_group;
	hsr_cmd_t    cmd_op;
	logic [15:0] cmd_data;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic        cal_summary;
	logic        hw2_summary;
	logic        am_fm_np;
	int          num_errors;
	int          n_tests;
	int          cycles;
	hsr_row_t    rows [8];

	hsr_status_regs u_hsr_status_regs (
		.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_group(cmd_group),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .clear_status(clear_status),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.acp_bw_inconsistent(cond_hw[11]), .acp_bw_too_wide(cond_hw[10]),
		.first_audio_generator_notch_range(cond_hw[9]),
		.second_audio_generator_voltage_high(cond_hw[8]),
		.fm_deviation_too_large(cond_hw[7]), .am_fm_requested(cond_hw[6]),
		.audio_autorange_error(cond_hw[5]), .offset_freq_mismatch(cond_hw[2]),
		.gen_amplitude_too_high(cond_hw[1]), .ref_level_out_of_range(cond_hw[0]),
		.tx_autozero_failed(cond_cal[4]), .voltmeter_cal_failed(cond_cal[3]),
		.counter_cal_failed(cond_cal[2]), .sampler_cal_failed(cond_cal[1]),
		.spectrum_cal_failed(cond_cal[0]), .cal_summary(cal_summary),
		.second_hardware_group_summary(hw2_summary), .am_fm_not_permitted(am_fm_np));

	hsr_ctrl_model u_hsr_ctrl_model (
		.clk(clk), .cmd_valid(cmd_valid), .cmd_group(cmd_group), .cmd_op(cmd_op),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic check1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic rd(input hsr_grp_t g, input hsr_cmd_t op, input logic [15:0] exp);
		logic [15:0] q;
		logic        v;
		u_hsr_ctrl_model.xfer(g, op, 16'h0000, q, v);
		check1(v, 1'b1);
		check16(q, exp);
	endtask

	task automatic wr(input hsr_grp_t g, input hsr_cmd_t op, input logic [15:0] d);
		logic [15:0] q;
		logic        v;
		u_hsr_ctrl_model.xfer(g, op, d, q, v);
	endtask

	// New raw inputs, then two edges for condition and event to settle
	task automatic set_cond(input hsr_grp_t g, input logic [15:0] v);
		@(posedge clk);
		if (g == HSR_GRP_HW2) cond_hw <= v;
		else cond_cal <= v;
		repeat (2) @(posedge clk);
		// Look at outputs away from the edge that launches them
		@(negedge clk);
	endtask

	task automatic pulse_cls();
		@(posedge clk);
		clear_status <= 1'b1;
		@(posedge clk);
		clear_status <= 1'b0;
	endtask

	function automatic logic sum_of(input hsr_grp_t g);
		return (g == HSR_GRP_HW2) ? hw2_summary : cal_summary;
	endfunction

	task automatic check_reset_vals();
		for (int i = 0; i < 2; i++) begin
			rd(hsr_grp_t'(i), HSR_CMD_RD_RISE, HSR_RISE_RST);
			rd(hsr_grp_t'(i), HSR_CMD_RD_FALL, HSR_FALL_RST);
			rd(hsr_grp_t'(i), HSR_CMD_RD_ENABLE, HSR_ENABLE_RST);
			rd(hsr_grp_t'(i), HSR_CMD_RD_EVENT, HSR_EVENT_RST);
			rd(hsr_grp_t'(i), HSR_CMD_RD_COND, 16'h0000);
			check1(sum_of(hsr_grp_t'(i)), 1'b0);
		end
	endtask

	task automatic summarize();
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard; the full run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end

	initial begin
		rst = 1'b1;
		clear_status = 1'b0;
		cond_hw = 16'h0000;
		cond_cal = 16'h0000;
		num_errors = 0;
		n_tests = 0;
		cycles = 0;
		rows[0] = '{HSR_GRP_HW2, 16'hffff, 16'h7fff, 16'h0800, 16'h0fe7, 16'h0fe7, 1'b1};
		rows[1] = '{HSR_GRP_HW2, 16'h0c00, 16'h0400, 16'h0800, 16'h0c00, 16'h0400, 1'b0};
		rows[2] = '{HSR_GRP_HW2, 16'h0300, 16'h0300, 16'h0100, 16'h0300, 16'h0300, 1'b1};
		rows[3] = '{HSR_GRP_HW2, 16'h00e0, 16'h00a0, 16'h0040, 16'h00e0, 16'h00a0, 1'b0};
		rows[4] = '{HSR_GRP_HW2, 16'h001f, 16'h0005, 16'h0004, 16'h0007, 16'h0005, 1'b1};
		rows[5] = '{HSR_GRP_CAL, 16'hffff, 16'h7fff, 16'h0010, 16'h001f, 16'h001f, 1'b1};
		rows[6] = '{HSR_GRP_CAL, 16'h0018, 16'h0008, 16'h0010, 16'h0018, 16'h0008, 1'b0};
		rows[7] = '{HSR_GRP_CAL, 16'h0007, 16'h0006, 16'h0001, 16'h0007, 16'h0006, 1'b0};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		check_reset_vals();
		// Table of ordinary cases
		foreach (rows[i]) begin
			set_cond(rows[i].g, 16'h0000);
			wr(rows[i].g, HSR_CMD_WR_RISE, rows[i].rise);
			wr(rows[i].g, HSR_CMD_WR_FALL, 16'h0000);
			wr(rows[i].g, HSR_CMD_WR_ENABLE, rows[i].en);
			pulse_cls();
			set_cond(rows[i].g, rows[i].cin);
			check1(sum_of(rows[i].g), rows[i].x_sum);
			rd(rows[i].g, HSR_CMD_RD_COND, rows[i].x_cond);
			rd(rows[i].g, HSR_CMD_RD_RISE, rows[i].rise);
			rd(rows[i].g, HSR_CMD_RD_ENABLE, rows[i].en);
			rd(rows[i].g, HSR_CMD_RD_EVENT, rows[i].x_ev);
			check1(sum_of(rows[i].g), 1'b0);
			rd(rows[i].g, HSR_CMD_RD_EVENT, 16'h0000);
		end
		// Both AM and FM asked for: flagged one cycle later
		set_cond(HSR_GRP_HW2, 16'h0040);
		check1(am_fm_np, 1'b1);
		set_cond(HSR_GRP_HW2, 16'h0000);
		check1(am_fm_np, 1'b0);
		// Falling edge through the fall filter, clear-status on both groups
		wr(HSR_GRP_HW2, HSR_CMD_WR_RISE, 16'h0000);
		wr(HSR_GRP_HW2, HSR_CMD_WR_FALL, 16'h0004);
		wr(HSR_GRP_HW2, HSR_CMD_WR_ENABLE, 16'h0004);
		rd(HSR_GRP_HW2, HSR_CMD_RD_FALL, 16'h0004);
		set_cond(HSR_GRP_HW2, 16'h0004);
		check1(hw2_summary, 1'b0);
		set_cond(HSR_GRP_HW2, 16'h0000);
		check1(hw2_summary, 1'b1);
		set_cond(HSR_GRP_CAL, 16'h0000);
		wr(HSR_GRP_CAL, HSR_CMD_WR_ENABLE, 16'h0002);
		set_cond(HSR_GRP_CAL, 16'h0002);
		check1(cal_summary, 1'b1);
		pulse_cls();
		@(posedge clk);
		@(negedge clk);
		check1(hw2_summary, 1'b0);
		check1(cal_summary, 1'b0);
		rd(HSR_GRP_CAL, HSR_CMD_RD_EVENT, 16'h0000);
		// Writing zero to enable clears every bit
		wr(HSR_GRP_HW2, HSR_CMD_WR_ENABLE, 16'h0000);
		rd(HSR_GRP_HW2, HSR_CMD_RD_ENABLE, 16'h0000);
		// Second reset in mid-run
		set_cond(HSR_GRP_CAL, 16'h0000);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		check_reset_vals();
		summarize();
	end
endmodule
